// >>> rtl/clock_source_and_low_power_control.v
// Purpose: clock source selection, divider, wait/stop control and write protection
// Assumes: Avalon-MM slave with waitrequest; oscillator levels arrive as pins
// Notes: oscillator pins and the nmi_n pin pass two flip-flops first
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`include "clk_ctl_defines.vh"

module clock_source_and_low_power_control (
	input wire sys_clk,
	input wire rstn,
	input wire [`ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire main_osc_in,
	input wire sub_osc_in,
	input wire pll_clk_in,
	input wire alt_osc_in,
	input wire nmi_n,
	input wire wake_irq,
	input wire cpu_wait_req,
	input wire cpu_write_strobe,
	output wire main_osc_enable,
	output wire sub_osc_enable,
	output wire sub_osc_drive_high,
	output wire pll_on,
	output wire bus_wait_state_select,
	output reg cpu_clk_q,
	output wire cpu_run,
	output wire periph_run,
	output wire sub_timer_run,
	output wire stop_mode,
	output wire wait_mode,
	output reg queue_release_q,
	output reg wake_event_q
);

localparam PM_RUN = 2'h0;
localparam PM_PREFETCH = 2'h1;
localparam PM_STOP = 2'h2;
localparam PM_WAIT = 2'h3;

// decode one aligned register offset
function hit;
	input [`ADDR_W-1:0] addr;
	input [`ADDR_W-1:0] ofs;
	begin
		hit = (addr == ofs);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [4:0] pin_raw;
wire [4:0] pin_s;
reg [4:0] sync1_q;
reg [4:0] sync2_q;

assign pin_raw = {nmi_n, alt_osc_in, pll_clk_in, sub_osc_in, main_osc_in};
assign pin_s = sync2_q;

genvar gi;
generate
	for (gi = 0; gi < 5; gi = gi + 1)
	begin : g_sync
		always @(posedge sys_clk)
		begin
			if (!rstn)
			begin
				sync1_q[gi] <= (gi == 4) ? 1'b1 : 1'b0;
				sync2_q[gi] <= (gi == 4) ? 1'b1 : 1'b0;
			end
			else
			begin
				sync1_q[gi] <= pin_raw[gi];
				sync2_q[gi] <= sync1_q[gi];
			end
		end
	end
endgenerate

wire main_s = pin_s[0];
wire sub_s = pin_s[1];
wire pll_s = pin_s[2];
wire alt_s = pin_s[3];
wire nmi_n_s = pin_s[4];

////////////////////////////////////////////////////////////////////////////////
// avalon slave

reg ack_q;
reg [7:0] ctrl0_q;
reg [7:0] ctrl1_q;
reg [7:0] ctrl2_q;
reg [7:0] pll_q;
reg [7:0] pmode1_q;
reg [`DIV_W-1:0] div_q;
reg [2:0] prot_q;
reg [1:0] pm_q;
reg [`PREFETCH_W-1:0] pf_cnt_q;
wire [1:0] sel_cur;
wire sw_busy;

assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

wire wr_go = avs_write & ack_q;
wire wr_ctrl0 = wr_go & hit(avs_address, `OFS_CTRL0) & prot_q[`B_PROT_CLK];
wire wr_ctrl1 = wr_go & hit(avs_address, `OFS_CTRL1) & prot_q[`B_PROT_CLK];
wire wr_ctrl2 = wr_go & hit(avs_address, `OFS_CTRL2) & prot_q[`B_PROT_CLK];
wire wr_pll = wr_go & hit(avs_address, `OFS_PLL) & prot_q[`B_PROT_CLK];
wire wr_pmode1 = wr_go & hit(avs_address, `OFS_PMODE1) & prot_q[`B_PROT_MODE];
wire wr_div = wr_go & hit(avs_address, `OFS_DIV) & prot_q[`B_PROT_TWO];
wire wr_prot = wr_go & hit(avs_address, `OFS_PROT);

wire [7:0] status_w = {2'h0, sw_busy, sel_cur, nmi_n_s, pm_q};

always @(posedge sys_clk)
begin
	if (!rstn)
	begin
		ack_q <= 1'b0;
		avs_readdata <= 32'h0;
	end
	else
	begin
		ack_q <= (avs_read | avs_write) & ~ack_q;
		if (avs_read & ~ack_q)
		begin
			case (avs_address)
				`OFS_CTRL0: avs_readdata <= {24'h0, ctrl0_q};
				`OFS_CTRL1: avs_readdata <= {24'h0, ctrl1_q};
				`OFS_CTRL2: avs_readdata <= {24'h0, ctrl2_q};
				`OFS_PLL: avs_readdata <= {24'h0, pll_q};
				`OFS_PMODE1: avs_readdata <= {24'h0, pmode1_q};
				`OFS_DIV: avs_readdata <= {27'h0, div_q};
				`OFS_PROT: avs_readdata <= {29'h0, prot_q};
				`OFS_STATUS: avs_readdata <= {24'h0, status_w};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control registers and write protection

wire stop_enter = (pm_q == PM_PREFETCH) && (pf_cnt_q == `PREFETCH_CYCLES);
wire stop_exit = (pm_q == PM_STOP) && (wake_irq || !nmi_n_s);
wire stop_abort = (pm_q == PM_PREFETCH) && !nmi_n_s;

always @(posedge sys_clk)
begin
	if (!rstn)
	begin
		ctrl0_q <= `RST_CTRL0;
		ctrl1_q <= `RST_CTRL1;
		ctrl2_q <= `RST_CTRL2;
		pll_q <= `RST_PLL;
		pmode1_q <= `RST_PMODE1;
		div_q <= `RST_DIV;
		prot_q <= `RST_PROT;
	end
	else
	begin
		if (wr_ctrl0)
			ctrl0_q <= avs_writedata[7:0];
		if (stop_enter)
			ctrl0_q[`B_DRIVE_HIGH] <= 1'b1;
		if (wr_ctrl1)
		begin
			ctrl1_q <= avs_writedata[7:0];
			ctrl1_q[`B_ALL_STOP] <= avs_writedata[`B_ALL_STOP] & nmi_n_s & (pm_q == PM_RUN);
		end
		// stop bit ends with wake-up or abort
		if (stop_exit || stop_abort)
			ctrl1_q[`B_ALL_STOP] <= 1'b0;
		if (wr_ctrl2)
			ctrl2_q <= avs_writedata[7:0];
		if (wr_pll)
			pll_q <= avs_writedata[7:0];
		if (wr_pmode1)
			pmode1_q <= avs_writedata[7:0];
		if (wr_div)
			div_q <= avs_writedata[`DIV_W-1:0];
		if (wr_prot)
			prot_q <= avs_writedata[2:0];
		else if (wr_go | cpu_write_strobe)
			prot_q[`B_PROT_TWO] <= 1'b0;
	end
end

assign sub_osc_drive_high = ctrl0_q[`B_DRIVE_HIGH];
assign sub_osc_enable = ctrl0_q[`B_SUB_EN];
assign main_osc_enable = ~ctrl0_q[`B_MAIN_STOP] & (pm_q != PM_STOP);
assign pll_on = pll_q[`B_PLL_ON] & (pm_q != PM_STOP);
assign bus_wait_state_select = pmode1_q[`B_WAIT_STATE];

////////////////////////////////////////////////////////////////////////////////
// power mode sequencer

always @(posedge sys_clk)
begin
	if (!rstn)
	begin
		pm_q <= PM_RUN;
		pf_cnt_q <= {`PREFETCH_W{1'b0}};
		queue_release_q <= 1'b0;
		wake_event_q <= 1'b0;
	end
	else
	begin
		queue_release_q <= 1'b0;
		wake_event_q <= queue_release_q;
		case (pm_q)
			PM_RUN:
			begin
				pf_cnt_q <= {`PREFETCH_W{1'b0}};
				if (ctrl1_q[`B_ALL_STOP])
					pm_q <= PM_PREFETCH;
				else if (cpu_wait_req)
					pm_q <= PM_WAIT;
			end
			PM_PREFETCH:
			begin
				pf_cnt_q <= pf_cnt_q + 1'b1;
				if (!nmi_n_s)
					pm_q <= PM_RUN;
				else if (stop_enter)
					pm_q <= PM_STOP;
			end
			PM_STOP:
			begin
				// queued instruction runs before wake event
				if (stop_exit)
				begin
					pm_q <= PM_RUN;
					queue_release_q <= 1'b1;
				end
			end
			PM_WAIT:
			begin
				if (wake_irq || !nmi_n_s)
				begin
					pm_q <= PM_RUN;
					queue_release_q <= 1'b1;
				end
			end
			default:
				pm_q <= PM_RUN;
		endcase
	end
end

assign stop_mode = (pm_q == PM_STOP);
assign wait_mode = (pm_q == PM_WAIT);
assign cpu_run = (pm_q == PM_RUN) || (pm_q == PM_PREFETCH);
assign periph_run = cpu_run || (wait_mode && !ctrl0_q[`B_PERIPH_STOP]);
// sub timer clock survives peripheral stop
assign sub_timer_run = ctrl0_q[`B_SUB_EN] && !stop_mode;

////////////////////////////////////////////////////////////////////////////////
// source selection, divider and glitch-free switch

reg [1:0] sel_req;
always @*
begin
	if (ctrl0_q[`B_CPU_SUB])
		sel_req = `SRC_SUB;
	else if (ctrl2_q[`B_ALT_SEL])
		sel_req = `SRC_ALT;
	else if (ctrl1_q[`B_MAIN_PLL])
		sel_req = `SRC_PLL;
	else
		sel_req = `SRC_MAIN;
end

wire [3:0] src_level = {sub_s, alt_s, pll_s, main_s};
wire sw_clk;

glitch_free_switch u_switch (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.src_level(src_level),
	.sel_req(sel_req),
	.clk_out_q(sw_clk),
	.sel_cur(sel_cur),
	.busy(sw_busy)
);

// divider counts rising edges; sub clock bypasses it
reg sw_clk_d1_q;
reg [`DIV_W-1:0] div_cnt_q;
reg div_out_q;
wire sw_rise = sw_clk & ~sw_clk_d1_q;
wire div_bypass = (sel_cur == `SRC_SUB) || (div_q <= 5'h01);

always @(posedge sys_clk)
begin
	if (!rstn)
	begin
		sw_clk_d1_q <= 1'b0;
		div_cnt_q <= {`DIV_W{1'b0}};
		div_out_q <= 1'b0;
		cpu_clk_q <= 1'b0;
	end
	else
	begin
		sw_clk_d1_q <= sw_clk;
		if (sw_rise)
		begin
			if (div_cnt_q >= div_q - 5'h01)
			begin
				div_cnt_q <= {`DIV_W{1'b0}};
				div_out_q <= 1'b1;
			end
			else
			begin
				div_cnt_q <= div_cnt_q + 5'h01;
				if (div_cnt_q == ((div_q >> 1) - 5'h01))
					div_out_q <= 1'b0;
			end
		end
		if (!cpu_run)
			cpu_clk_q <= 1'b0;
		else if (div_bypass)
			cpu_clk_q <= sw_clk;
		else
			cpu_clk_q <= div_out_q;
	end
end

endmodule // clock_source_and_low_power_control

// >>> common/clk_ctl_defines.vh
// Purpose: constants of the clock source and low-power control block
// Assumes: 32-bit Avalon-MM data, byte addresses
// Notes: offsets are byte addresses, one aligned word per register
`ifndef CLK_CTL_DEFINES_VH
`define CLK_CTL_DEFINES_VH

`define ADDR_W 6
`define OFS_CTRL0 6'h00
`define OFS_CTRL1 6'h04
`define OFS_CTRL2 6'h08
`define OFS_PLL 6'h0C
`define OFS_PMODE1 6'h10
`define OFS_DIV 6'h14
`define OFS_PROT 6'h18
`define OFS_STATUS 6'h1C

// clock_control_reg_zero fields
`define B_PERIPH_STOP 2
`define B_DRIVE_HIGH 3
`define B_SUB_EN 4
`define B_MAIN_STOP 5
`define B_CPU_SUB 7
// clock_control_reg_one fields
`define B_ALL_STOP 0
`define B_MAIN_PLL 7
// clock_control_reg_two fields
`define B_ALT_SEL 1
// pll_control_reg fields
`define B_PLL_ON 7
// processor_mode_reg_one fields
`define B_WAIT_STATE 2
// protect register fields
`define B_PROT_CLK 0
`define B_PROT_MODE 1
`define B_PROT_TWO 2
// divide field
`define DIV_W 5

// reset values
`define RST_CTRL0 8'h08
`define RST_CTRL1 8'h00
`define RST_CTRL2 8'h00
`define RST_PLL 8'h00
`define RST_PMODE1 8'h00
`define RST_DIV 5'h08
`define RST_PROT 3'h0

// prefetch slots that run before the clocks halt
`define PREFETCH_CYCLES 3'h4
`define PREFETCH_W 3

// cpu clock source codes
`define SRC_MAIN 2'h0
`define SRC_PLL 2'h1
`define SRC_ALT 2'h2
`define SRC_SUB 2'h3

`endif

// >>> rtl/glitch_free_switch.v
// Purpose: switches the cpu clock level between sampled sources without glitches
// Assumes: source levels are already synchronised to sys_clk
// Notes: output is held low while the switch is in progress
`include "clk_ctl_defines.vh"

module glitch_free_switch (
	input wire sys_clk,
	input wire rstn,
	input wire [3:0] src_level,
	input wire [1:0] sel_req,
	output reg clk_out_q,
	output wire [1:0] sel_cur,
	output wire busy
);

localparam ST_RUN = 2'h0;
localparam ST_DROP = 2'h1;
localparam ST_ADOPT = 2'h2;

reg [1:0] st_q;
reg [1:0] cur_q;
reg [1:0] nxt_q;

assign sel_cur = cur_q;
assign busy = (st_q != ST_RUN);

always @(posedge sys_clk)
begin
	if (!rstn)
	begin
		st_q <= ST_RUN;
		cur_q <= `SRC_MAIN;
		nxt_q <= `SRC_MAIN;
		clk_out_q <= 1'b0;
	end
	else
	begin
		case (st_q)
			ST_RUN:
			begin
				clk_out_q <= src_level[cur_q];
				// leave old source only when low
				if (sel_req != cur_q && !src_level[cur_q])
				begin
					st_q <= ST_DROP;
					nxt_q <= sel_req;
					clk_out_q <= 1'b0;
				end
			end
			ST_DROP:
			begin
				clk_out_q <= 1'b0;
				if (!src_level[nxt_q])
					st_q <= ST_ADOPT;
			end
			ST_ADOPT:
			begin
				// join new source at a low phase
				cur_q <= nxt_q;
				clk_out_q <= 1'b0;
				st_q <= ST_RUN;
			end
			default:
			begin
				st_q <= ST_RUN;
				clk_out_q <= 1'b0;
			end
		endcase
	end
end

endmodule // glitch_free_switch

// >>> tb/osc_model.sv
// Purpose: behavioural oscillators on the far side of the block
// Assumes: enables come straight from the block's pins
// Notes: a stopped oscillator holds its pin low
module osc_model (
	input logic main_en,
	input logic sub_en,
	input logic pll_en,
	output logic main_osc_in,
	output logic sub_osc_in,
	output logic pll_clk_in,
	output logic alt_osc_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		main_osc_in = 1'h0;
		sub_osc_in = 1'h0;
		pll_clk_in = 1'h0;
		alt_osc_in = 1'h0;
	end
	always #30 main_osc_in = main_en ? ~main_osc_in : 1'h0;
	always #170 sub_osc_in = sub_en ? ~sub_osc_in : 1'h0;
	always #14 pll_clk_in = pll_en ? ~pll_clk_in : 1'h0;
	always #50 alt_osc_in = ~alt_osc_in;
endmodule // osc_model

// >>> tb/clk_ctl_chk.sv
// Purpose: port checks of the clock control block
// Assumes: one clock domain, reset rstn active low
// Notes: bound to the block's top module
module clk_ctl_chk (
	input logic sys_clk,
	input logic rstn,
	input logic avs_read,
	input logic avs_write,
	input logic avs_waitrequest,
	input logic nmi_n,
	input logic sub_osc_enable,
	input logic sub_osc_drive_high,
	input logic cpu_clk_q,
	input logic cpu_run,
	input logic sub_timer_run,
	input logic stop_mode,
	input logic wait_mode,
	input logic queue_release_q,
	input logic wake_event_q
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_stop_entry;
		$rose(stop_mode);
	endsequence
	sequence s_wake;
		queue_release_q ##1 wake_event_q;
	endsequence
	AST_STOP_DRIVE: assert property (s_stop_entry |-> sub_osc_drive_high)
		else $error("drive not high at stop entry");
	AST_NMI_BLOCK: assert property (!nmi_n [*5] |-> !$rose(stop_mode))
		else $error("stop entered with nmi low");
	AST_STOP_HALT: assert property (stop_mode |-> !cpu_run)
		else $error("cpu runs in stop");
	AST_HALT_CLK: assert property (stop_mode [*3] |-> !cpu_clk_q)
		else $error("cpu clock toggles in stop");
	AST_WAKE_SEQ: assert property ($fell(stop_mode) |-> ##[0:2] s_wake)
		else $error("queue release or wake event missing");
	AST_WAKE_CAUSE: assert property (queue_release_q |-> $past(stop_mode | wait_mode) | $past(stop_mode | wait_mode, 2))
		else $error("queue release without low power");
	AST_TIMER_RUN: assert property (wait_mode && sub_osc_enable |-> sub_timer_run)
		else $error("sub timer clock stopped in wait");
	AST_WAITREQ: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low in first cycle");
	cover property (s_stop_entry);
endmodule // clk_ctl_chk
bind clock_source_and_low_power_control clk_ctl_chk u_chk (.sys_clk, .rstn, .avs_read, .avs_write, .avs_waitrequest,
	.nmi_n, .sub_osc_enable, .sub_osc_drive_high, .cpu_clk_q, .cpu_run, .sub_timer_run, .stop_mode, .wait_mode,
	.queue_release_q, .wake_event_q);

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the clock control block
// Assumes: oscillator model on the far side
// Notes: a request completes at the rising edge where waitrequest is low
`include "clk_ctl_defines.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic nmi_n = 1'h1;
	logic wake_irq = 1'h0;
	logic cpu_wait_req = 1'h0;
	logic cpu_write_strobe = 1'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, main_osc_in, sub_osc_in, pll_clk_in, alt_osc_in, main_osc_enable, sub_osc_enable;
	logic sub_osc_drive_high, pll_on, bus_wait_state_select, cpu_clk_q, cpu_run, periph_run, sub_timer_run;
	logic stop_mode, wait_mode, queue_release_q, wake_event_q;
	logic [31:0] q;
	logic [31:0] rst_exp [0:7];
	int n_errors = 0;
	int cmp_count = 0;
	int i;
	always #10 sys_clk = ~sys_clk;
	clock_source_and_low_power_control dut (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .main_osc_in, .sub_osc_in, .pll_clk_in, .alt_osc_in, .nmi_n, .wake_irq,
		.cpu_wait_req, .cpu_write_strobe, .main_osc_enable, .sub_osc_enable, .sub_osc_drive_high, .pll_on,
		.bus_wait_state_select, .cpu_clk_q, .cpu_run, .periph_run, .sub_timer_run, .stop_mode, .wait_mode,
		.queue_release_q, .wake_event_q);
	osc_model u_osc (.main_en(main_osc_enable), .sub_en(sub_osc_enable), .pll_en(pll_on), .main_osc_in,
		.sub_osc_in, .pll_clk_in, .alt_osc_in);
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'h0 && n < 50)
		begin
			n++;
			@(posedge sys_clk);
		end
		if (n == 50)
		begin
			n_errors++;
			$display("BAD waitrequest expected 0 seen %h", avs_waitrequest);
		end
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
		bus(1'h0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic pin(input string nm, input logic e, input logic s);
		chk(nm, {31'h0, e}, {31'h0, s});
	endtask
	task automatic src(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
		bus(1'h1, a, d);
		q = 32'hFFFFFFFF;
		for (int k = 0; k < 40 && (q[4:3] !== e || q[5] !== 1'h0); k++)
			bus(1'h0, `OFS_STATUS, 32'h0);
		chk("cpu source", {30'h0, e}, {30'h0, q[4:3]});
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		n_errors++;
		print_verdict;
	end
	initial
	begin
		rst_exp = '{32'h8, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h4};
		repeat (2) @(posedge sys_clk);
		rstn <= 1'h1;
		@(posedge sys_clk);
		for (i = 0; i < 8; i++)
			rd(6'(i * 4), rst_exp[i], "reset value");
		rd(6'h20, 32'h0, "unmapped");
		bus(1'h1, `OFS_CTRL0, 32'h10);
		rd(`OFS_CTRL0, 32'h8, "locked ctrl0");
		bus(1'h1, `OFS_PROT, 32'h4);
		pin("wait state low", 1'h0, bus_wait_state_select);
		bus(1'h1, `OFS_DIV, 32'h3);
		rd(`OFS_DIV, 32'h3, "div unlocked");
		rd(`OFS_PROT, 32'h0, "prot two");
		bus(1'h1, `OFS_DIV, 32'h5);
		rd(`OFS_DIV, 32'h3, "div relocked");
		bus(1'h1, `OFS_PROT, 32'h4);
		cpu_write_strobe <= 1'h1;
		@(posedge sys_clk);
		cpu_write_strobe <= 1'h0;
		bus(1'h1, `OFS_DIV, 32'h6);
		rd(`OFS_DIV, 32'h3, "div after cpu write");
		// stop entry under low nmi
		bus(1'h1, `OFS_PROT, 32'h3);
		// start sub oscillator at high drive, then lower
		bus(1'h1, `OFS_CTRL0, 32'h18);
		bus(1'h1, `OFS_CTRL0, 32'h10);
		pin("sub_osc_enable", 1'h1, sub_osc_enable);
		pin("drive_high", 1'h0, sub_osc_drive_high);
		// main clock stopped in stop, pll off before stop
		nmi_n <= 1'h0;
		repeat (4) @(posedge sys_clk);
		bus(1'h1, `OFS_CTRL1, 32'h1);
		rd(`OFS_CTRL1, 32'h0, "stop refused");
		pin("stop_mode", 1'h0, stop_mode);
		nmi_n <= 1'h1;
		repeat (4) @(posedge sys_clk);
		bus(1'h1, `OFS_CTRL1, 32'h1);
		for (i = 0; i < 20 && stop_mode !== 1'h1; i++)
			@(posedge sys_clk);
		@(negedge sys_clk);
		pin("stop_mode", 1'h1, stop_mode);
		pin("drive_high", 1'h1, sub_osc_drive_high);
		pin("cpu_run", 1'h0, cpu_run);
		pin("main_osc_enable", 1'h0, main_osc_enable);
		// irq wake, release pulse stands for the jump
		@(posedge sys_clk);
		wake_irq <= 1'h1;
		@(posedge sys_clk);
		wake_irq <= 1'h0;
		repeat (3) @(posedge sys_clk);
		rd(`OFS_CTRL1, 32'h0, "stop bit after wake");
		rd(`OFS_CTRL0, 32'h18, "drive after stop");
		pin("cpu_run", 1'h1, cpu_run);
		// nmi wake, dummy interrupt taken before
		bus(1'h1, `OFS_CTRL1, 32'h1);
		for (i = 0; i < 20 && stop_mode !== 1'h1; i++)
			@(posedge sys_clk);
		@(negedge sys_clk);
		pin("stop_mode before nmi", 1'h1, stop_mode);
		@(posedge sys_clk);
		nmi_n <= 1'h0;
		repeat (4) @(posedge sys_clk);
		nmi_n <= 1'h1;
		repeat (4) @(posedge sys_clk);
		pin("stop_mode after nmi", 1'h0, stop_mode);
		rd(`OFS_CTRL1, 32'h0, "stop bit after nmi");
		// wait mode with peripheral stop, sub timer kept running
		bus(1'h1, `OFS_CTRL0, 32'h14);
		cpu_wait_req <= 1'h1;
		@(posedge sys_clk);
		cpu_wait_req <= 1'h0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		pin("wait_mode", 1'h1, wait_mode);
		pin("periph_run", 1'h0, periph_run);
		pin("sub_timer_run", 1'h1, sub_timer_run);
		@(posedge sys_clk);
		wake_irq <= 1'h1;
		@(posedge sys_clk);
		wake_irq <= 1'h0;
		repeat (3) @(posedge sys_clk);
		pin("wait_mode", 1'h0, wait_mode);
		// drive low, sub, then alt, then pll, each back to main
		src(`OFS_CTRL0, 32'h90, 2'h3);
		src(`OFS_CTRL0, 32'h10, 2'h0);
		src(`OFS_CTRL2, 32'h2, 2'h2);
		src(`OFS_CTRL2, 32'h0, 2'h0);
		bus(1'h1, `OFS_PLL, 32'h80);
		pin("pll_on", 1'h1, pll_on);
		src(`OFS_CTRL1, 32'h80, 2'h1);
		src(`OFS_CTRL1, 32'h0, 2'h0);
		q = 32'h0;
		repeat (40) @(posedge sys_clk) q = q | (32'h1 << cpu_clk_q);
		chk("cpu clock toggles", 32'h3, q);
		bus(1'h1, `OFS_PMODE1, 32'h4);
		pin("bus_wait_state_select", 1'h1, bus_wait_state_select);
		print_verdict;
	end
endmodule // tb_top
